//--- include/hpct_pkg.sv
// Notes on behaviour
// - Firmware-requested changes appear at next frame end, except port four resume (timer expiry)
// - Endpoint byte marks changed ports and hub
// - One change flag per reset, suspend, enable, connect
// - Bit four flags completed port reset
// - Ports one-three: reset flag ten ms later
// - Port four: reset flag at late frame point
// - Bit two flags completed resume
// - Ports one-three: flag after resume completes
// - Port four: twenty ms after late frame
// - Status word: flags low, upper eleven zero
// - Enable flag set by hardware events only
// - Connect state sampled at late frame point
package hpct_pkg;
   localparam int CLK_KHZ = 40000;
   localparam int RST_WAIT_MS = 10;
   localparam int RES_WAIT_MS = 20;
   localparam int RST_WAIT_CYC = RST_WAIT_MS * CLK_KHZ;
   localparam int RES_WAIT_CYC = RES_WAIT_MS * CLK_KHZ;
   localparam int CNT_W = 20;
   localparam int NPORT = 4;
   localparam int P4 = 3;
   localparam logic [7:0] IDX_FLAGS = 8'hD5;
   localparam logic [7:0] IDX_PSEL = 8'hD6;
   localparam logic [7:0] IDX_TXB = 8'hD7;
   localparam logic [7:0] IDX_IRQ_ST = 8'hD8;
   localparam logic [7:0] IDX_IRQ_EN = 8'hD9;
   localparam logic [7:0] IDX_IRQ_CLR = 8'hDA;
   localparam logic [4:0] FLAG_MASK = 5'h17;
   localparam logic [4:0] FLAG_RST = 5'h10;
   localparam logic [4:0] FLAG_SUSP = 5'h04;
   localparam logic [4:0] FLAG_EN = 5'h02;
   localparam logic [4:0] FLAG_CONN = 5'h01;
   localparam logic [3:0] CONN_RST = 4'h8;
   localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
   typedef struct packed {
      logic rst;
      logic gap;
      logic susp;
      logic en;
      logic conn;
   } hpct_flags_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] idx;
      logic sel0;
      logic [7:0] dat;
   } hpct_wbreq_t;
endpackage : hpct_pkg

//--- logic/hpct_tracker.sv
`timescale 1ns/1ps
module hpct_tracker
   import hpct_pkg::*;
#(
   parameter int RST_CYC = RST_WAIT_CYC,
   parameter int RES_CYC = RES_WAIT_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [11:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic LATE_FRAME,
   input wire logic [2:0] RESET_CMD,
   input wire logic RESET4_DONE,
   input wire logic [3:0] RESUME_DONE,
   input wire logic [3:0] ENABLE_LOST,
   input wire logic [2:0] CONNECT_PIN,
   input wire logic HUB_CHANGE,
   output logic [7:0] TX_BYTE,
   output logic [15:0] STATUS_WORD,
   output logic IRQ
);
   hpct_wbreq_t rq;
   hpct_flags_t [3:0] flags_r, flags_nxt;
   logic [3:0][CNT_W-1:0] tmr_r, tmr_nxt;
   logic [3:0] rst_pend_r, rst_pend_nxt;
   logic [3:0] sus_pend_r, sus_pend_nxt;
   logic res4_wait_r, res4_wait_nxt;
   logic [2:0] conn_s1_r, conn_s2_r;
   logic [3:0] conn_q_r, conn_q_nxt;
   logic [1:0] psel_r, psel_nxt;
   logic [3:0] irq_st_r, irq_st_nxt;
   logic [3:0] irq_en_r, irq_en_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic [7:0] txb_r, txb_nxt;
   logic [15:0] sw_r, sw_nxt;
   logic irq_r, irq_nxt;
   logic [3:0] conn_now;
   logic req, wr;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN || !CE);

   function automatic logic [7:0] flag_byte(hpct_flags_t f);
      flag_byte = {3'h0, f & FLAG_MASK};
   endfunction : flag_byte

   assign rq = '{WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I[9:2],
                 WB_SEL_I[0], WB_DAT_I[7:0]};
   assign req = rq.cyc && rq.stb && !ack_r;
   assign wr = req && rq.we && rq.sel0;
   assign conn_now = {1'b1, conn_s2_r};

   always_comb begin
      hpct_flags_t set;
      hpct_flags_t clr;
      flags_nxt = flags_r;
      tmr_nxt = tmr_r;
      rst_pend_nxt = rst_pend_r;
      sus_pend_nxt = sus_pend_r;
      res4_wait_nxt = res4_wait_r;
      conn_q_nxt = conn_q_r;
      irq_st_nxt = irq_st_r;
      set = '0;
      clr = '0;
      if (RESUME_DONE[P4]) begin
         res4_wait_nxt = 1'b1;
      end
      for (int p = 0; p < NPORT; p++) begin
         set = '0;
         clr = '0;
         if (tmr_r[p] != CNT_ZERO) begin
            tmr_nxt[p] = tmr_r[p] - CNT_ONE;
         end
         if (p != P4) begin
            if (RESET_CMD[p]) begin
               tmr_nxt[p] = CNT_W'(RST_CYC);
            end
            if (tmr_r[p] == CNT_ONE) begin
               rst_pend_nxt[p] = 1'b1;
            end
            if (RESUME_DONE[p]) begin
               sus_pend_nxt[p] = 1'b1;
            end
            if (ENABLE_LOST[p]) begin
               set = set | FLAG_EN;
            end
         end else begin
            if (RESET4_DONE) begin
               rst_pend_nxt[p] = 1'b1;
            end
            if (tmr_r[p] == CNT_ONE) begin
               set = set | FLAG_SUSP;
            end
            if (LATE_FRAME && res4_wait_r) begin
               tmr_nxt[p] = CNT_W'(RES_CYC);
               res4_wait_nxt = RESUME_DONE[P4];
            end
         end
         if (LATE_FRAME) begin
            // Commit only at frame end; a late event stays pending
            if (rst_pend_r[p]) begin
               set = set | FLAG_RST;
               rst_pend_nxt[p] = 1'b0;
            end
            if (sus_pend_r[p]) begin
               set = set | FLAG_SUSP;
               sus_pend_nxt[p] = 1'b0;
            end
            if (p == P4 && ENABLE_LOST[p]) begin
               set = set | FLAG_EN;
            end
            conn_q_nxt[p] = conn_now[p];
            if (conn_now[p] != conn_q_r[p]) begin
               set = set | FLAG_CONN;
            end
         end
         if (wr && rq.idx == IDX_FLAGS && psel_r == 2'(p)) begin
            clr = hpct_flags_t'(rq.dat[4:0]);
         end
         // Set beats a simultaneous clear
         flags_nxt[p] = (flags_r[p] & ~clr | set) & FLAG_MASK;
         if ((set & FLAG_MASK) != '0) begin
            irq_st_nxt[p] = 1'b1;
         end else if (wr && rq.idx == IDX_IRQ_CLR && rq.dat[p]) begin
            irq_st_nxt[p] = 1'b0;
         end
      end
   end

   always_comb begin
      psel_nxt = psel_r;
      irq_en_nxt = irq_en_r;
      ack_nxt = req;
      dat_nxt = dat_r;
      if (wr && rq.idx == IDX_PSEL) begin
         psel_nxt = rq.dat[1:0];
      end
      if (wr && rq.idx == IDX_IRQ_EN) begin
         irq_en_nxt = rq.dat[3:0];
      end
      if (req && !rq.we) begin
         case (rq.idx)
            IDX_FLAGS: dat_nxt = {24'h0, flag_byte(flags_r[psel_r])};
            IDX_PSEL: dat_nxt = {30'h0, psel_r};
            IDX_TXB: dat_nxt = {24'h0, txb_r};
            IDX_IRQ_ST: dat_nxt = {28'h0, irq_st_r};
            IDX_IRQ_EN: dat_nxt = {28'h0, irq_en_r};
            default: dat_nxt = 32'h0;
         endcase
      end
      for (int p = 0; p < NPORT; p++) begin
         txb_nxt[p+1] = |flags_r[p];
      end
      txb_nxt[0] = HUB_CHANGE;
      txb_nxt[7:5] = 3'h0;
      sw_nxt = {11'h0, flags_r[psel_r] & FLAG_MASK};
      irq_nxt = |(irq_st_r & irq_en_r);
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         flags_r <= '0;
         tmr_r <= '0;
         rst_pend_r <= 4'h0;
         sus_pend_r <= 4'h0;
         res4_wait_r <= 1'b0;
         conn_s1_r <= 3'h0;
         conn_s2_r <= 3'h0;
         conn_q_r <= CONN_RST;
         psel_r <= 2'h0;
         irq_st_r <= 4'h0;
         irq_en_r <= 4'h0;
         ack_r <= 1'b0;
         dat_r <= 32'h0;
         txb_r <= 8'h0;
         sw_r <= 16'h0;
         irq_r <= 1'b0;
      end else if (CE) begin
         flags_r <= flags_nxt;
         tmr_r <= tmr_nxt;
         rst_pend_r <= rst_pend_nxt;
         sus_pend_r <= sus_pend_nxt;
         res4_wait_r <= res4_wait_nxt;
         conn_s1_r <= CONNECT_PIN;
         conn_s2_r <= conn_s1_r;
         conn_q_r <= conn_q_nxt;
         psel_r <= psel_nxt;
         irq_st_r <= irq_st_nxt;
         irq_en_r <= irq_en_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         txb_r <= txb_nxt;
         sw_r <= sw_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = dat_r;
   assign TX_BYTE = txb_r;
   assign STATUS_WORD = sw_r;
   assign IRQ = irq_r;

   logic [3:0] rst_v, sus_v, en_v;
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         rst_v[p] = flags_r[p].rst;
         sus_v[p] = flags_r[p].susp;
         en_v[p] = flags_r[p].en;
      end
   end

   sequence s_req;
      req;
   endsequence
   sequence s_ans;
      ##1 WB_ACK_O ##1 !WB_ACK_O;
   endsequence

   property p_ack;
      s_req |-> s_ans;
   endproperty
   a_ack: assert property (p_ack) else $error("ack timing wrong");

   property p_rsv;
      WB_ACK_O && !rq.we && $past(rq.idx == IDX_FLAGS)
         |-> WB_DAT_O[31:5] == 27'h0 && !WB_DAT_O[3];
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");

   property p_rst_defer;
      $rose(rst_v[0]) |-> $past(LATE_FRAME);
   endproperty
   a_rst_defer: assert property (p_rst_defer)
      else $error("reset flag early");

   // Expiry and frame commit are two steps; a merged expiry shows as flag
   sequence s_rst_expire;
      tmr_r[0] == CNT_ONE;
   endsequence
   sequence s_rst_commit;
      rst_pend_r[0] && LATE_FRAME;
   endsequence

   property p_rst_tmr;
      s_rst_expire |=> rst_pend_r[0] || rst_v[0];
   endproperty
   a_rst_tmr: assert property (p_rst_tmr)
      else $error("reset flag missed");

   property p_rst_commit;
      s_rst_commit |=> rst_v[0];
   endproperty
   a_rst_commit: assert property (p_rst_commit)
      else $error("reset flag not committed");

   property p_clr;
      wr && rq.idx == IDX_FLAGS && psel_r == 2'h0 && rq.dat[4] && !LATE_FRAME
         |=> !rst_v[0];
   endproperty
   a_clr: assert property (p_clr)
      else $error("reset flag not cleared");

   property p_res4_start;
      LATE_FRAME && res4_wait_r |=> tmr_r[P4] == CNT_W'(RES_CYC);
   endproperty
   a_res4_start: assert property (p_res4_start)
      else $error("port four resume timer not started");

   property p_res4;
      tmr_r[P4] == CNT_ONE |=> sus_v[P4];
   endproperty
   a_res4: assert property (p_res4)
      else $error("port four resume missed");

   property p_en_hw;
      $rose(en_v[1]) |-> $past(ENABLE_LOST[1]);
   endproperty
   a_en_hw: assert property (p_en_hw)
      else $error("enable flag without event");

   property p_en4;
      $rose(en_v[P4]) |-> $past(LATE_FRAME && ENABLE_LOST[P4]);
   endproperty
   a_en4: assert property (p_en4)
      else $error("port four enable flag off frame point");

   property p_conn;
      LATE_FRAME && conn_now[2] != conn_q_r[2] |=> flags_r[2].conn;
   endproperty
   a_conn: assert property (p_conn)
      else $error("connect change missed");

   property p_txb;
      flags_r[2] != '0 |=> TX_BYTE[3];
   endproperty
   a_txb: assert property (p_txb) else $error("tx byte bit missing");

   property p_word;
      ##1 STATUS_WORD[15:5] == 11'h0 && !STATUS_WORD[3];
   endproperty
   a_word: assert property (p_word)
      else $error("status word upper bits");

   property p_irq;
      (irq_st_r & irq_en_r) != 4'h0 |=> IRQ;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised");
endmodule : hpct_tracker

//--- verification/hpct_host_frm.sv
`timescale 1ns/1ps
module hpct_host_frm
   import hpct_pkg::*;
#(
   parameter int PERIOD = 64
) (
   input wire logic clk,
   input wire logic rst_n,
   output logic late_frame
);
   // Fixed frame rhythm; short so the bench stays fast
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   always_comb begin
      cnt_nxt = (cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
   end
   always_ff @(posedge clk) begin
      if (!rst_n)
         cnt_r <= 8'h00;
      else
         cnt_r <= cnt_nxt;
   end
   assign late_frame = (cnt_r == 8'(PERIOD - 1));
endmodule : hpct_host_frm

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import hpct_pkg::*;
   localparam int SC = 30;
   localparam int FP = 64;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic ack, lf, irq;
   logic [2:0] rcmd = 3'h0;
   logic [2:0] pin = 3'h0;
   logic r4 = 1'b0;
   logic hub = 1'b0;
   logic [3:0] res = 4'h0;
   logic [3:0] lost = 4'h0;
   logic [7:0] txb, q;
   logic [15:0] sw;
   int bad_count = 0;
   int num_checks = 0;
   always #12.5 clk = ~clk;
   hpct_tracker #(.RST_CYC(20), .RES_CYC(SC)) u_hpct_tracker (
      .CLK_SYS(clk), .RESETN(rst_n), .CE(1'b1), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1),
      .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .LATE_FRAME(lf), .RESET_CMD(rcmd), .RESET4_DONE(r4),
      .RESUME_DONE(res), .ENABLE_LOST(lost), .CONNECT_PIN(pin),
      .HUB_CHANGE(hub), .TX_BYTE(txb), .STATUS_WORD(sw), .IRQ(irq));
   hpct_host_frm #(.PERIOD(FP)) u_hpct_host_frm (
      .clk(clk), .rst_n(rst_n), .late_frame(lf));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {2'b00, idx, 2'b00};
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      // Gap cycle so ack can fall before the next request
      @(posedge clk);
      if (n >= 20) begin
         bad_count++;
         give_verdict();
      end
   endtask : bus
   task automatic rdf(input logic [7:0] e);
      bus(1'b0, IDX_FLAGS, 8'h00);
      chk("flags", {8'h00, e}, {8'h00, q});
   endtask : rdf
   task automatic frame;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (lf !== 1'b1 && n < 200);
      if (n >= 200) begin
         bad_count++;
         give_verdict();
      end
   endtask : frame
   initial begin
      tick(3);
      rst_n <= 1'b1;
      tick(1);
      rdf(8'h00);
      chk("tx", 16'h0000, {8'h00, txb});
      bus(1'b0, 8'hF0, 8'h00);
      chk("unmapped", 16'h0000, {8'h00, q});
      bus(1'b1, IDX_IRQ_EN, 8'h01);
      frame();
      rcmd <= 3'h1;
      tick(1);
      rcmd <= 3'h0;
      tick(25);
      rdf(8'h00);
      frame();
      rdf(8'h10);
      chk("tx", 16'h0002, {8'h00, txb});
      chk("status", 16'h0010, sw);
      chk("irq", 16'h0001, {15'h0000, irq});
      bus(1'b1, IDX_FLAGS, 8'h00);
      rdf(8'h10);
      bus(1'b1, IDX_FLAGS, 8'h10);
      rdf(8'h00);
      bus(1'b1, IDX_IRQ_CLR, 8'h01);
      chk("irq", 16'h0000, {15'h0000, irq});
      bus(1'b1, IDX_PSEL, 8'h03);
      frame();
      r4 <= 1'b1;
      tick(1);
      r4 <= 1'b0;
      tick(5);
      rdf(8'h00);
      frame();
      rdf(8'h10);
      bus(1'b1, IDX_FLAGS, 8'h10);
      bus(1'b1, IDX_PSEL, 8'h00);
      frame();
      res <= 4'h9;
      tick(1);
      res <= 4'h0;
      frame();
      rdf(8'h04);
      bus(1'b1, IDX_PSEL, 8'h03);
      rdf(8'h00);
      tick(SC);
      rdf(8'h04);
      chk("status", 16'h0004, sw);
      // Port four loss off the frame point must not flag
      lost <= 4'hA;
      tick(1);
      lost <= 4'h0;
      bus(1'b1, IDX_PSEL, 8'h01);
      rdf(8'h02);
      bus(1'b1, IDX_PSEL, 8'h03);
      rdf(8'h04);
      // Port four loss on the frame point does flag
      frame();
      tick(FP - 1);
      lost <= 4'h8;
      tick(1);
      lost <= 4'h0;
      rdf(8'h06);
      bus(1'b0, IDX_IRQ_ST, 8'h00);
      chk("irq_st", 16'h000B, {8'h00, q});
      chk("irq", 16'h0001, {15'h0000, irq});
      hub <= 1'b1;
      tick(2);
      chk("tx", 16'h0017, {8'h00, txb});
      bus(1'b0, IDX_TXB, 8'h00);
      chk("tx_reg", 16'h0017, {8'h00, q});
      pin <= 3'h4;
      tick(3);
      frame();
      bus(1'b1, IDX_PSEL, 8'h02);
      rdf(8'h01);
      // Mid-run reset clears every flag and output
      hub <= 1'b0;
      rst_n <= 1'b0;
      tick(3);
      rst_n <= 1'b1;
      tick(1);
      chk("tx", 16'h0000, {8'h00, txb});
      rdf(8'h00);
      chk("status", 16'h0000, sw);
      chk("irq", 16'h0000, {15'h0000, irq});
      give_verdict();
   end
endmodule : tb_top
